// >>> src/hwmon_pkg.sv
package hwmon_pkg;

	// ************************************************************
	// register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [7:0] IDX_BEEP_ONE = 8'h56;
	localparam logic [7:0] IDX_BEEP_TWO = 8'h57;
	localparam logic [7:0] IDX_CHIP_IDENTITY = 8'h58;
	localparam logic [7:0] IDX_DIODE_DIV = 8'h59;
	localparam logic [7:0] IDX_BATT_CTRL = 8'h5d;
	localparam logic [7:0] IDX_PWM_FREQ = 8'h60;
	localparam logic [7:0] IDX_OUT_VALUE = 8'h61;
	localparam logic [7:0] IDX_FAN_CFG = 8'h62;
	localparam logic [7:0] IDX_TARGET = 8'h63;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] RST_BEEP_ONE = 8'h00;
	localparam logic [7:0] RST_BEEP_TWO = 8'h80;
	localparam logic [7:0] RST_DIODE_DIV = 8'h70;
	localparam logic [7:0] RST_BATT_CTRL = 8'h00;
	localparam logic [7:0] RST_PWM_FREQ = 8'h04;
	localparam logic [7:0] RST_OUT_VALUE = 8'hff;
	localparam logic [7:0] RST_FAN_CFG = 8'h40;
	localparam logic [7:0] RST_TARGET = 8'h00;
	// arbitrary neutral identification value
	localparam logic [7:0] CHIP_IDENTITY_VALUE = 8'h5a;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BEEP_GLOBAL_BIT = 7;
	localparam int BEEP_TWO_SRC_MSB = 5;
	localparam int DIODE_MODEL_LSB = 4;
	localparam int AUX1_DIV_HI_BIT = 7;
	localparam int AUX1_DIV_LO_LSB = 2;
	localparam int PROC1_DIV_LO_LSB = 0;
	localparam int BATT_DIV_HI_LSB = 5;
	localparam int SENSOR_TYPE_LSB = 1;
	localparam int BATT_ENABLE_BIT = 0;
	localparam int PWM_CLK_SEL_BIT = 7;
	localparam int PWM_PRESCALE_MSB = 6;
	localparam int DC_LEVEL_LSB = 2;
	localparam int FAN_STYLE_BIT = 6;
	localparam int FAN_MODE_LSB = 4;
	localparam int FAN_TOL_MSB = 3;
	localparam int TARGET_TEMP_MSB = 6;
	localparam logic [7:0] DUTY_FULL = 8'hff;

	// ************************************************************
	// fan control modes and bus encodings
	// ************************************************************
	typedef enum logic [1:0] {
		MODE_MANUAL = 2'b00,
		MODE_THERMAL_CRUISE = 2'b01,
		MODE_SPEED_CRUISE = 2'b10,
		MODE_CURVE = 2'b11
	} fan_mode_e;
	localparam int NUM_FANS = 5;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic HRESP_OKAY = 1'b0;

endpackage

// >>> src/hwmon_beep_fan_control.sv
`timescale 1ns/1ps
module hwmon_beep_fan_control (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// alarm sources and beeper
	input wire logic [7:0] violation_one_i,
	input wire logic [5:0] violation_two_i,
	output logic beep_o,
	// temperature sensor front end
	output logic [2:0] sensor_is_diode_o,
	output logic [2:0] diode_cpu_model_o,
	// fan tachometers
	input wire logic [5:0] div_low_ext_i,
	input wire logic [hwmon_pkg::NUM_FANS-1:0] tach_pulse_i,
	output logic [hwmon_pkg::NUM_FANS-1:0] tach_count_o,
	// battery monitor
	input wire logic monitor_cycle_start_i,
	input wire logic monitor_cycle_done_i,
	output logic battery_enable_o,
	output logic battery_update_o,
	// fan drive
	input wire logic src_tick_24m_i,
	input wire logic src_tick_180k_i,
	output logic fan_drive_output_o,
	output logic fan_dc_style_o,
	output logic [5:0] fan_dc_level_o,
	output logic [1:0] fan_mode_o,
	output logic [3:0] fan_tolerance_o,
	output logic [6:0] target_temp_o,
	output logic [7:0] target_speed_o
);
	import hwmon_pkg::*;

	// ************************************************************
	// bus slave
	// ************************************************************
	// only haddr bits 9:2 decode, so higher bits alias the same word
	// hsize is not checked: every access is taken as a whole word
	// upper data bits are dropped on writes and read back as zero
	logic [7:0] beep_enable_one;
	logic [7:0] beep_enable_two;
	logic [7:0] diode_and_divisor_select;
	logic [7:0] battery_monitor_control;
	logic [7:0] fan_pwm_frequency;
	logic [7:0] fan_output_value;
	logic [7:0] fan_configuration;
	logic [7:0] target_value;
	logic dp_write;
	logic dp_read;
	logic [7:0] dp_index;
	logic rd_done;
	logic addr_phase;
	logic [7:0] read_mux;

	// a transfer is taken when selected, nonseq and the bus is ready
	assign addr_phase = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);

	// latch the address phase for the data phase
	// the index is latched on every ready cycle, wanted or not
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dp_write <= 1'b0;
			dp_read <= 1'b0;
			dp_index <= 8'h00;
		end else if (ce_i) begin
			if (hready_i) begin
				dp_write <= addr_phase & hwrite_i;
				dp_read <= addr_phase & ~hwrite_i;
				dp_index <= haddr_i[9:2];
			end
		end
	end

	// reads carry one wait state so hrdata comes from a flop
	// rd_done lasts one cycle, so back-to-back reads each wait once
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_done <= 1'b0;
		end else if (ce_i) begin
			rd_done <= dp_read & ~rd_done;
		end
	end

	// first data cycle of a read waits while the multiplexer settles
	logic read_wait;

	assign read_wait = dp_read & ~rd_done;
	// a frozen block holds the bus rather than lose a write
	assign hreadyout_o = ce_i & ~read_wait;
	assign hresp_o = HRESP_OKAY;

	// read multiplexer; unmapped and reserved read as zero
	// the index held from the address phase picks the register
	always_comb begin
		case (dp_index)
			IDX_BEEP_ONE: read_mux = beep_enable_one;
			IDX_BEEP_TWO: read_mux = beep_enable_two;
			IDX_CHIP_IDENTITY: read_mux = CHIP_IDENTITY_VALUE;
			IDX_DIODE_DIV: read_mux = diode_and_divisor_select;
			IDX_BATT_CTRL: read_mux = battery_monitor_control;
			IDX_PWM_FREQ: read_mux = fan_pwm_frequency;
			IDX_OUT_VALUE: read_mux = fan_output_value;
			IDX_FAN_CFG: read_mux = fan_configuration;
			IDX_TARGET: read_mux = target_value;
			default: read_mux = 8'h00;
		endcase
	end

	// read data captured in the wait cycle
	// hrdata holds its value until the next read replaces it
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			if (dp_read & ~rd_done) begin
				hrdata_o <= {24'h00_0000, read_mux};
			end
		end
	end

	// ************************************************************
	// register file
	// ************************************************************
	// writes land at the end of the data phase; chip_identity has no store
	// reserved bits are masked on the way in so they always read zero
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			beep_enable_one <= RST_BEEP_ONE;
			beep_enable_two <= RST_BEEP_TWO;
			diode_and_divisor_select <= RST_DIODE_DIV;
			battery_monitor_control <= RST_BATT_CTRL;
			fan_pwm_frequency <= RST_PWM_FREQ;
			fan_output_value <= RST_OUT_VALUE;
			fan_configuration <= RST_FAN_CFG;
			target_value <= RST_TARGET;
		end else if (ce_i && dp_write) begin
			case (dp_index)
				IDX_BEEP_ONE: beep_enable_one <= hwdata_i[7:0];
				// bit 6 reserved, reads zero
				IDX_BEEP_TWO: beep_enable_two <= hwdata_i[7:0] & 8'hbf;
				IDX_DIODE_DIV: diode_and_divisor_select <= hwdata_i[7:0];
				// bit 4 reserved, reads zero
				IDX_BATT_CTRL: battery_monitor_control <= hwdata_i[7:0] & 8'hef;
				IDX_PWM_FREQ: fan_pwm_frequency <= hwdata_i[7:0];
				IDX_OUT_VALUE: fan_output_value <= hwdata_i[7:0];
				// bit 7 reserved, reads zero
				IDX_FAN_CFG: fan_configuration <= hwdata_i[7:0] & 8'h7f;
				IDX_TARGET: target_value <= hwdata_i[7:0];
				default: ;
			endcase
		end
	end

	// ************************************************************
	// beeper
	// ************************************************************
	logic [7:0] hits_one;
	logic [5:0] hits_two;
	logic any_beep_src;

	// a source counts only while its own enable bit is set
	assign hits_one = violation_one_i & beep_enable_one;
	// bit 6 of register two is reserved and never a source
	assign hits_two = violation_two_i
		& beep_enable_two[BEEP_TWO_SRC_MSB:0];
	// violations are levels; the beeper sounds while any one stands
	assign any_beep_src = (|hits_one) | (|hits_two);

	// registered so the beeper sees a clean level
	// clearing the gate mutes the pin within one cycle
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			beep_o <= 1'b0;
		end else if (ce_i) begin
			beep_o <= beep_enable_two[BEEP_GLOBAL_BIT] & any_beep_src;
		end
	end

	// ************************************************************
	// temperature sensor selects
	// ************************************************************
	// the front end decides what a diode model means; this block
	// only forwards the selects, a thermistor input sees model 0
	// order in both fields: bit 2 aux, bit 1 processor, bit 0 system
	assign sensor_is_diode_o =
		battery_monitor_control[SENSOR_TYPE_LSB +: 3];
	// model only means something for a diode input
	assign diode_cpu_model_o = sensor_is_diode_o
		& diode_and_divisor_select[DIODE_MODEL_LSB +: 3];

	// ************************************************************
	// fan tachometer divisors
	// ************************************************************
	// a code change acts at once; a count already above the new
	// limit ends on the next pulse, so the counter never stalls
	// fan order: 0 proc0, 1 system, 2 aux0, 3 aux1, 4 proc1
	logic [2:0] div_code [NUM_FANS];

	assign div_code[0] = {battery_monitor_control[BATT_DIV_HI_LSB + 1],
		div_low_ext_i[1:0]};
	assign div_code[1] = {battery_monitor_control[BATT_DIV_HI_LSB],
		div_low_ext_i[3:2]};
	assign div_code[2] = {battery_monitor_control[BATT_DIV_HI_LSB + 2],
		div_low_ext_i[5:4]};
	assign div_code[3] = {diode_and_divisor_select[AUX1_DIV_HI_BIT],
		diode_and_divisor_select[AUX1_DIV_LO_LSB +: 2]};
	// high bit of proc1 lives outside this block and reads as zero
	assign div_code[4] = {1'b0,
		diode_and_divisor_select[PROC1_DIV_LO_LSB +: 2]};

	generate
		for (genvar f = 0; f < NUM_FANS; f++) begin : g_tach
			logic [6:0] tach_cnt;
			logic [6:0] div_last;

			// divisor 2**code, so terminal count is that minus one
			assign div_last = 7'((8'd1 << div_code[f]) - 8'd1);

			// one counting pulse per divisor tach pulses
			// pulses arriving while frozen are lost, not queued
			always_ff @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					tach_cnt <= 7'd0;
					tach_count_o[f] <= 1'b0;
				end else if (ce_i) begin
					tach_count_o[f] <= 1'b0;
					if (tach_pulse_i[f]) begin
						if (tach_cnt >= div_last) begin
							tach_cnt <= 7'd0;
							tach_count_o[f] <= 1'b1;
						end else begin
							tach_cnt <= tach_cnt + 7'd1;
						end
					end
				end
			end
		end
	endgenerate

	// ************************************************************
	// battery monitor
	// ************************************************************
	logic batt_en_q;
	logic batt_armed;
	logic batt_rising;

	assign battery_enable_o = battery_monitor_control[BATT_ENABLE_BIT];
	// the cycle that sees a 0-to-1 change of the enable bit
	assign batt_rising = battery_enable_o & ~batt_en_q;

	// after enabling, a cycle already under way is not trusted
	// the sequencer refreshes the reading; this block only strobes
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			batt_en_q <= 1'b0;
			batt_armed <= 1'b0;
			battery_update_o <= 1'b0;
		end else if (ce_i) begin
			batt_en_q <= battery_enable_o;
			battery_update_o <= battery_enable_o & batt_en_q
				& batt_armed & monitor_cycle_done_i;
			if (!battery_enable_o || batt_rising) begin
				batt_armed <= 1'b0;
			end else if (monitor_cycle_start_i) begin
				batt_armed <= 1'b1;
			end
		end
	end

	// ************************************************************
	// fan drive
	// ************************************************************
	logic src_tick;
	logic [6:0] prescale;
	logic [6:0] pre_cnt;
	logic pre_tick;
	logic [7:0] pwm_cnt;
	logic pwm_active;

	// mode, tolerance and targets only feed control loops outside
	assign fan_dc_style_o = fan_configuration[FAN_STYLE_BIT];
	assign fan_mode_o = fan_configuration[FAN_MODE_LSB +: 2];
	assign fan_tolerance_o = fan_configuration[FAN_TOL_MSB:0];
	// dc level keeps the top six bits, bits 1:0 unused
	assign fan_dc_level_o = fan_output_value[7:DC_LEVEL_LSB];
	// meaning depends on mode; both views of one register
	assign target_temp_o = target_value[TARGET_TEMP_MSB:0];
	assign target_speed_o = target_value;

	// source clock arrives as a tick enable in this domain
	// a tick held high counts on every cycle
	assign src_tick = fan_pwm_frequency[PWM_CLK_SEL_BIT]
		? src_tick_180k_i : src_tick_24m_i;
	// a forbidden zero is run as one rather than stall the fan
	assign prescale = (fan_pwm_frequency[PWM_PRESCALE_MSB:0] == 7'd0)
		? 7'd1 : fan_pwm_frequency[PWM_PRESCALE_MSB:0];
	// the prescaler wraps on the tick that reaches the divisor
	assign pre_tick = src_tick && (pre_cnt >= prescale - 7'd1);

	// prescaler and period counter run only in pwm style
	// dc style parks both so pwm restarts from a clean period
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pre_cnt <= 7'd0;
			pwm_cnt <= 8'h00;
		end else if (ce_i) begin
			if (fan_dc_style_o) begin
				pre_cnt <= 7'd0;
				pwm_cnt <= 8'h00;
			end else if (src_tick) begin
				if (pre_tick) begin
					pre_cnt <= 7'd0;
					pwm_cnt <= pwm_cnt + 8'd1;
				end else begin
					pre_cnt <= pre_cnt + 7'd1;
				end
			end
		end
	end

	logic duty_full;
	logic duty_below;

	// full-scale value is held fully on, 100% rather than 255/256
	assign duty_full = (fan_output_value == DUTY_FULL);
	// active while the period count is still below the duty value
	assign duty_below = (pwm_cnt < fan_output_value);
	assign pwm_active = duty_full | duty_below;

	// output flop; idle low in dc style where the analog level rules
	// one cycle behind the counter, harmless at fan rates
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fan_drive_output_o <= 1'b0;
		end else if (ce_i) begin
			fan_drive_output_o <= ~fan_dc_style_o & pwm_active;
		end
	end

endmodule

// >>> testbench/hwmon_beep_fan_control_checker.sv
`timescale 1ns/1ps
module hwmon_beep_fan_control_checker (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic [7:0] violation_one_i,
	input wire logic [5:0] violation_two_i,
	input wire logic beep_o,
	input wire logic [2:0] sensor_is_diode_o,
	input wire logic [2:0] diode_cpu_model_o,
	input wire logic [hwmon_pkg::NUM_FANS-1:0] tach_pulse_i,
	input wire logic [hwmon_pkg::NUM_FANS-1:0] tach_count_o,
	input wire logic monitor_cycle_done_i,
	input wire logic battery_update_o,
	input wire logic fan_drive_output_o,
	input wire logic fan_dc_style_o
);
	import hwmon_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	logic tk;
	// transfer accepted at this edge
	assign tk = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ) & ce_i;
	chk_resp_okay: assert property (hresp_o == HRESP_OKAY)
		else $error("bus response not okay");
	chk_read_wait: assert property (tk && !hwrite_i
		|=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait state wrong");
	chk_write_nowait: assert property (tk && hwrite_i |=> hreadyout_o)
		else $error("write stalled");
	chk_beep_cause: assert property (beep_o
		|-> $past(|{violation_two_i, violation_one_i}))
		else $error("beep without violation");
	chk_model_diode: assert property (
		(diode_cpu_model_o & ~sensor_is_diode_o) == 3'h0)
		else $error("diode model on thermistor input");
	chk_dc_drive_low: assert property (fan_dc_style_o
		&& $past(fan_dc_style_o) |-> !fan_drive_output_o)
		else $error("pwm active in dc style");
	chk_tach_cause: assert property (
		(tach_count_o & ~$past(tach_pulse_i)) == 5'h0)
		else $error("tach count without pulse");
	chk_batt_update: assert property (battery_update_o
		|-> $past(monitor_cycle_done_i))
		else $error("battery update without done");
	cov_read: cover property (tk && !hwrite_i);
	cov_beep: cover property (beep_o);
	cov_batt: cover property (battery_update_o);
	cov_tach: cover property (tach_count_o[4]);
endmodule
bind hwmon_beep_fan_control hwmon_beep_fan_control_checker chk_u (.*);

// >>> testbench/fan_beeper_model.sv
`timescale 1ns/1ps
module fan_beeper_model (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic spin_i,
	input wire logic clr_i,
	input wire logic drive_i,
	output logic tick_24m_o,
	output logic tick_180k_o,
	output logic [4:0] tach_o,
	output int high_cnt_o
);
	logic ph;
	// half-rate phase: slow source and tach pulses never back to back
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			ph <= 1'b0;
		else
			ph <= !ph;
	end
	assign tick_24m_o = 1'b1; // fast source ticks every cycle
	assign tick_180k_o = ph;
	assign tach_o = {5{spin_i & ph}};
	// time the drive is active, for duty measurement
	always_ff @(posedge clk_i) begin
		if (clr_i)
			high_cnt_o <= 0;
		else if (drive_i === 1'b1)
			high_cnt_o <= high_cnt_o + 1;
	end
endmodule

// >>> testbench/hwmon_beep_fan_control_tb.sv
`timescale 1ns/1ps
module hwmon_beep_fan_control_tb;
	import hwmon_pkg::*;
	logic clk = 0, arst_n = 0, hsel = 0, hwrite = 0, spin = 0, clr = 0;
	logic mstart = 0, mdone = 0, hrdy, hresp, beep, ben, bupd, t24, t180;
	logic fdrv, dcs;
	logic [1:0] htrans = 0, mode;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rdat;
	logic [7:0] v1 = 0, tspd;
	logic [5:0] v2 = 0, lvl;
	logic [2:0] sdio, dmod;
	logic [4:0] tcnt, tach;
	logic [3:0] tol;
	logic [6:0] ttemp;
	logic [13:0] en;
	int hi, n_fail = 0, check_count = 0, nupd = 0, tc[5] = '{0, 0, 0, 0, 0};
	logic [7:0] ix[10] = '{IDX_BEEP_ONE, IDX_BEEP_TWO, IDX_CHIP_IDENTITY,
		IDX_DIODE_DIV, IDX_BATT_CTRL, IDX_PWM_FREQ, IDX_OUT_VALUE,
		IDX_FAN_CFG, IDX_TARGET, 8'h5a};
	logic [7:0] rv[10] = '{RST_BEEP_ONE, RST_BEEP_TWO, CHIP_IDENTITY_VALUE,
		RST_DIODE_DIV, RST_BATT_CTRL, RST_PWM_FREQ, RST_OUT_VALUE,
		RST_FAN_CFG, RST_TARGET, 8'h00};
	logic [7:0] fv[10] = '{8'hff, 8'hbf, CHIP_IDENTITY_VALUE, 8'hff, 8'hef,
		8'hff, 8'hff, 8'h7f, 8'hff, 8'h00};
	logic [7:0] pf[5] = '{8'h01, 8'h02, 8'h81, 8'h01, 8'h01};
	logic [7:0] pd[5] = '{8'h40, 8'h40, 8'h40, 8'h00, 8'hff};
	int pn[5] = '{512, 1024, 1024, 512, 512};
	int pe[5] = '{128, 256, 256, 0, 512};
	int te[5] = '{2, 64, 8, 2, 16};

	hwmon_beep_fan_control dut_u (.clk_i(clk), .arst_n_i(arst_n),
		.ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
		.hresp_o(hresp), .violation_one_i(v1), .violation_two_i(v2),
		.beep_o(beep), .sensor_is_diode_o(sdio), .diode_cpu_model_o(dmod),
		.div_low_ext_i(6'h31), .tach_pulse_i(tach), .tach_count_o(tcnt),
		.monitor_cycle_start_i(mstart), .monitor_cycle_done_i(mdone),
		.battery_enable_o(ben), .battery_update_o(bupd),
		.src_tick_24m_i(t24), .src_tick_180k_i(t180),
		.fan_drive_output_o(fdrv), .fan_dc_style_o(dcs),
		.fan_dc_level_o(lvl), .fan_mode_o(mode), .fan_tolerance_o(tol),
		.target_temp_o(ttemp), .target_speed_o(tspd));
	fan_beeper_model far_u (.clk_i(clk), .arst_n_i(arst_n), .spin_i(spin),
		.clr_i(clr), .drive_i(fdrv), .tick_24m_o(t24), .tick_180k_o(t180),
		.tach_o(tach), .high_cnt_o(hi));

	always #10 clk = !clk;
	// output pulse tallies, sampled as they stood before each edge
	always @(posedge clk) begin
		for (int k = 0; k < 5; k++)
			if (tcnt[k] === 1'b1)
				tc[k]++;
		if (bupd === 1'b1)
			nupd++;
	end

	// ************************************************************
	// bus and compare tasks
	// ************************************************************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// wait for hready, judged just before the edge that samples it
	task automatic cyc;
		do @(negedge clk); while (hrdy !== 1'b1);
		rdat = hrdata;
		@(posedge clk);
	endtask
	task automatic acc(input logic [7:0] i, input logic w,
		input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {22'h0, i, 2'h0};
		cyc;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		cyc;
		if (!w)
			chk(rdat, {24'h0, d});
	endtask
	task automatic stop_test;
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// hang guard, well beyond the roughly 9.6k cycles of the tests
	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		stop_test;
	end

	// ************************************************************
	// test sequence
	// ************************************************************
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		foreach (ix[k]) acc(ix[k], 1'b0, rv[k]);
		foreach (ix[k]) acc(ix[k], 1'b1, 8'hff);
		foreach (ix[k]) acc(ix[k], 1'b0, fv[k]);
		for (int m = 0; m < 4; m++) begin
			acc(IDX_FAN_CFG, 1'b1, 8'h40 | 8'(m * 17));
			#1 chk(mode, m);
			chk(tol, m);
			@(posedge clk);
		end
		acc(IDX_TARGET, 1'b1, 8'ha5);
		#1 chk(ttemp, 32'h25);
		chk(tspd, 32'ha5);
		@(posedge clk);
		acc(IDX_BATT_CTRL, 1'b1, 8'h0a);
		acc(IDX_DIODE_DIV, 1'b1, 8'h20);
		#1 chk(dmod, 3'h0);
		@(posedge clk);
		acc(IDX_DIODE_DIV, 1'b1, 8'h50);
		#1 chk(sdio, 3'h5);
		chk(dmod, 3'h5);
		@(posedge clk);
		// one source enabled at a time, others all violating
		for (int b = 0; b < 14; b++) begin
			en = 14'h1 << b;
			acc(IDX_BEEP_ONE, 1'b1, en[7:0]);
			acc(IDX_BEEP_TWO, 1'b1, {2'b10, en[13:8]});
			{v2, v1} <= ~en;
			repeat (3) @(posedge clk);
			#1 chk(beep, 0);
			@(posedge clk);
			{v2, v1} <= en;
			repeat (3) @(posedge clk);
			#1 chk(beep, 1);
			@(posedge clk);
		end
		acc(IDX_BEEP_TWO, 1'b1, 8'h3f);
		repeat (3) @(posedge clk);
		#1 chk(beep, 0);
		@(posedge clk);
		{v2, v1} <= 14'h0;
		acc(IDX_BATT_CTRL, 1'b1, 8'h40);
		acc(IDX_DIODE_DIV, 1'b1, 8'h86);
		spin <= 1'b1;
		repeat (128) @(posedge clk);
		spin <= 1'b0;
		repeat (4) @(posedge clk);
		foreach (te[k]) chk(tc[k], te[k]);
		acc(IDX_BATT_CTRL, 1'b1, 8'h01);
		#1 chk(ben, 1);
		@(posedge clk);
		mdone <= 1'b1;
		@(posedge clk) mdone <= 1'b0;
		@(posedge clk) mstart <= 1'b1;
		@(posedge clk) mstart <= 1'b0;
		@(posedge clk) mdone <= 1'b1;
		@(posedge clk) mdone <= 1'b0;
		repeat (3) @(posedge clk);
		chk(nupd, 1);
		acc(IDX_FAN_CFG, 1'b1, 8'h00);
		// whole periods in each window, so phase does not matter
		for (int k = 0; k < 5; k++) begin
			acc(IDX_PWM_FREQ, 1'b1, pf[k]);
			acc(IDX_OUT_VALUE, 1'b1, pd[k]);
			repeat (1100) @(posedge clk);
			clr <= 1'b1;
			@(posedge clk) clr <= 1'b0;
			repeat (pn[k]) @(posedge clk);
			#1 chk(hi, pe[k]);
			@(posedge clk);
		end
		acc(IDX_OUT_VALUE, 1'b1, 8'h9c);
		acc(IDX_FAN_CFG, 1'b1, 8'h40);
		repeat (3) @(posedge clk);
		#1 chk(fdrv, 0);
		chk(lvl, 6'h27);
		chk(dcs, 1);
		stop_test;
	end
endmodule
